// *** rsc_cfg.svh ***
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

// one machine cycle = 12 oscillator periods; here counted in SYS_CLK cycles
`define RSC_MC_NS 480
`define RSC_CLK_NS 40
`define RSC_MC_CYC ((`RSC_MC_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
// width of the low-level counters
`define RSC_CNT_W 5
// pulse stretch of the reset request after a short power-down pulse
`define RSC_RST_HOLD 4

`endif

// *** rsc_pkg.sv ***
package rsc_pkg;

   typedef enum logic [2:0] {
      RSC_RUN = 3'b001,
      RSC_RST = 3'b010,
      RSC_PDN = 3'b100
   } rsc_state_e;

   typedef struct packed {
      logic rst_n;
      logic pd_n;
      logic osc_wdog_en;
      logic pswd_n;
   } rsc_pins_s;

   typedef struct packed {
      logic wdt_reset;
      logic osc_fail;
      logic ps_request;
   } rsc_core_s;

endpackage : rsc_pkg

// *** rsc_top.sv ***
`timescale 1ns/10ps
`include "rsc_cfg.svh"
module rsc_top #(
   parameter int MC_CYC = `RSC_MC_CYC
)(
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RST,
   // board pins
   input wire logic RESET_IN_N,
   input wire logic HARD_POWERDOWN_IN_N,
   input wire logic OSC_WDOG_ENABLE_STRAP,
   input wire logic POWER_SAVE_PERMIT_N,
   // core events
   input wire logic WDT_RESET,
   input wire logic OSC_FAIL,
   input wire logic PS_REQUEST,
   // outputs
   output logic RESET_REQUEST_OUT_N,
   output logic SYS_RESET,
   output logic OSC_WDOG_ON,
   output logic PS_GRANT,
   output logic WDT_AUTOSTART,
   output logic POWERDOWN,
   output logic PINS_FLOAT
);

   // ************************************************************
   // synchronizers
   // ************************************************************
   rsc_pkg::rsc_pins_s s1_q, s2_q, s1_d, s2_d;
   rsc_pkg::rsc_core_s core;

   always_comb
   begin
      s1_d = {RESET_IN_N, HARD_POWERDOWN_IN_N, OSC_WDOG_ENABLE_STRAP, POWER_SAVE_PERMIT_N};
      s2_d = s1_q;
      core = {WDT_RESET, OSC_FAIL, PS_REQUEST};
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (RST)
      begin
         s1_q <= 4'hf;
         s2_q <= 4'hf;
      end
      else
      begin
         s1_q <= s1_d;
         s2_q <= s2_d;
      end
   end

   // ************************************************************
   // low-level counters and state
   // ************************************************************
   localparam logic [`RSC_CNT_W-1:0] MC = `RSC_CNT_W'(MC_CYC);
   logic [`RSC_CNT_W-1:0] rcnt_q, rcnt_d, pcnt_q, pcnt_d;
   logic [2:0] hold_q, hold_d;
   rsc_pkg::rsc_state_e st_q, st_d;
   logic ext_rst, osc_rst, req;
   logic req_n_q, req_n_d, wds_q, wds_d, own_q, own_d, grant_q, grant_d;
   logic pd_q, pd_d, flt_q, flt_d, rel;
   logic srst_q, srst_d;
   logic [1:0] fill_q, fill_d;

   always_comb
   begin
      rcnt_d = s2_q.rst_n ? '0 : (rcnt_q == MC ? MC : rcnt_q + 1'b1);
      pcnt_d = s2_q.pd_n ? '0 : (pcnt_q == MC + MC ? pcnt_q : pcnt_q + 1'b1);
      ext_rst = (rcnt_q == MC);
      own_d = s2_q.osc_wdog_en;
      osc_rst = own_q && core.osc_fail;
      hold_d = hold_q == 3'h0 ? 3'h0 : hold_q - 3'h1;
      // short power-down pulse ends: stretch the reset so it is seen
      if (s2_q.pd_n && pcnt_q >= MC && pcnt_q < MC + MC)
         hold_d = 3'(`RSC_RST_HOLD);
      // hold reset until both synchronizer stages carry real pin levels
      fill_d = {fill_q[0], 1'h1};
      req = ext_rst || core.wdt_reset || osc_rst || hold_q != 3'h0 || !fill_q[1];
      st_d = st_q;
      case (st_q)
         rsc_pkg::RSC_RUN:
            if (pcnt_q == MC + MC)
               st_d = rsc_pkg::RSC_PDN;
            else if (req)
               st_d = rsc_pkg::RSC_RST;
         rsc_pkg::RSC_RST:
            if (pcnt_q == MC + MC)
               st_d = rsc_pkg::RSC_PDN;
            else if (!req)
               st_d = rsc_pkg::RSC_RUN;
         rsc_pkg::RSC_PDN:
            if (s2_q.pd_n)
               st_d = rsc_pkg::RSC_RST; // wake through reset
         default:
            st_d = rsc_pkg::RSC_RST;
      endcase
      rel = (st_q == rsc_pkg::RSC_RST) && (st_d == rsc_pkg::RSC_RUN);
      req_n_d = !(st_d != rsc_pkg::RSC_RUN);
      wds_d = rel ? s2_q.pswd_n : (st_d == rsc_pkg::RSC_RUN ? wds_q : 1'h0);
      grant_d = core.ps_request && !s2_q.pswd_n && st_q == rsc_pkg::RSC_RUN;
      pd_d = st_d == rsc_pkg::RSC_PDN;
      flt_d = st_d == rsc_pkg::RSC_PDN;
      srst_d = st_d != rsc_pkg::RSC_RUN;
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (RST)
      begin
         rcnt_q <= '0;
         pcnt_q <= '0;
         hold_q <= 3'h0;
         st_q <= rsc_pkg::RSC_RST;
         req_n_q <= 1'b0;
         wds_q <= 1'b0;
         own_q <= 1'b1;
         grant_q <= 1'b0;
         pd_q <= 1'b0;
         flt_q <= 1'b0;
         srst_q <= 1'h1;
         fill_q <= 2'h0;
      end
      else
      begin
         rcnt_q <= rcnt_d;
         pcnt_q <= pcnt_d;
         hold_q <= hold_d;
         st_q <= st_d;
         req_n_q <= req_n_d;
         wds_q <= wds_d;
         own_q <= own_d;
         grant_q <= grant_d;
         pd_q <= pd_d;
         flt_q <= flt_d;
         srst_q <= srst_d;
         fill_q <= fill_d;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   always_comb
   begin
      RESET_REQUEST_OUT_N = req_n_q;
      SYS_RESET = srst_q;
      OSC_WDOG_ON = own_q;
      PS_GRANT = grant_q;
      WDT_AUTOSTART = wds_q;
      POWERDOWN = pd_q;
      PINS_FLOAT = flt_q;
   end

   // ************************************************************
   // assertions
   // ************************************************************
   sequence s_rst_low_mc;
      rcnt_q == MC;
   endsequence

   property p_ext_rst;
      @(posedge SYS_CLK) disable iff (RST)
      s_rst_low_mc ##0 (pcnt_q != MC + MC) |=> !RESET_REQUEST_OUT_N;
   endproperty
   a_ext_rst: assert property (p_ext_rst) else $error("reset input did not reset");

   property p_out_pin;
      @(posedge SYS_CLK) disable iff (RST)
      (st_q == rsc_pkg::RSC_RST) |-> !RESET_REQUEST_OUT_N;
   endproperty
   a_out_pin: assert property (p_out_pin) else $error("reset output not low");

   property p_wdt_src;
      @(posedge SYS_CLK) disable iff (RST)
      core.wdt_reset |=> !RESET_REQUEST_OUT_N;
   endproperty
   a_wdt_src: assert property (p_wdt_src) else $error("watchdog reset ignored");

   property p_osc_wdog;
      @(posedge SYS_CLK) disable iff (RST)
      (s2_q.osc_wdog_en == 1'b0) |=> !OSC_WDOG_ON;
   endproperty
   a_osc_wdog: assert property (p_osc_wdog) else $error("osc watchdog on while strap low");

   property p_ps_allow;
      @(posedge SYS_CLK) disable iff (RST)
      (core.ps_request && !s2_q.pswd_n && st_q == rsc_pkg::RSC_RUN) |=> PS_GRANT;
   endproperty
   a_ps_allow: assert property (p_ps_allow) else $error("power save not granted");

   property p_ps_block;
      @(posedge SYS_CLK) disable iff (RST)
      s2_q.pswd_n |=> !PS_GRANT;
   endproperty
   a_ps_block: assert property (p_ps_block) else $error("power save not blocked");

   property p_wds_latch;
      @(posedge SYS_CLK) disable iff (RST)
      rel |=> (WDT_AUTOSTART == $past(s2_q.pswd_n));
   endproperty
   a_wds_latch: assert property (p_wds_latch) else $error("autostart not latched");

   property p_pdn;
      @(posedge SYS_CLK) disable iff (RST)
      (pcnt_q == MC + MC) && !s2_q.pd_n |=> POWERDOWN ##0 PINS_FLOAT;
   endproperty
   a_pdn: assert property (p_pdn) else $error("power-down not forced");

   property p_sync;
      @(posedge SYS_CLK) disable iff (RST)
      1'b1 |=> (s2_q == $past(s1_q));
   endproperty
   a_sync: assert property (p_sync) else $error("synchronizer broken");

endmodule : rsc_top

// *** rsc_board.sv ***
`timescale 1ns/10ps
// ****
// board side: reset circuit and strap levels
// ****
module rsc_board (
   // wishes from the bench
   input wire logic rst_low,
   input wire logic pd_low,
   input wire logic wdog_en,
   input wire logic ps_n,
   // pins
   output logic rst_n,
   output logic pd_n,
   output logic wdog_en_pin,
   output logic ps_pin
);
   // straps are static levels, no clock on this side
   assign rst_n = !rst_low;
   assign pd_n = !pd_low;
   assign wdog_en_pin = wdog_en;
   assign ps_pin = ps_n;
endmodule : rsc_board

// *** rsc_top_tb.sv ***
`timescale 1ns/10ps
module rsc_top_tb;
   logic clk = 0;
   logic rst = 1;
   logic rst_low = 0, pd_low = 0, wdog_en = 1, ps_n = 1;
   logic wdt = 0, osc = 0, psr = 0;
   logic rn, pn, op, pp, rqo_n, sr, ow, pg, wa, pdn, pf;
   int errors = 0;
   int comparisons = 0;
   rsc_board i_rsc_board (.rst_low(rst_low), .pd_low(pd_low), .wdog_en(wdog_en), .ps_n(ps_n),
      .rst_n(rn), .pd_n(pn), .wdog_en_pin(op), .ps_pin(pp));
   rsc_top i_rsc_top (.SYS_CLK(clk), .RST(rst), .RESET_IN_N(rn), .HARD_POWERDOWN_IN_N(pn),
      .OSC_WDOG_ENABLE_STRAP(op), .POWER_SAVE_PERMIT_N(pp), .WDT_RESET(wdt),
      .OSC_FAIL(osc), .PS_REQUEST(psr), .RESET_REQUEST_OUT_N(rqo_n), .SYS_RESET(sr),
      .OSC_WDOG_ON(ow), .PS_GRANT(pg), .WDT_AUTOSTART(wa), .POWERDOWN(pdn),
      .PINS_FLOAT(pf));
   initial
   begin
      forever #20 clk = !clk;
   end
   task step(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task chk(string name, logic exp, logic got);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %s expected %b seen %b", name, exp, got);
      end
   endtask : chk
   task give_verdict;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict
   // ****
   // scenarios
   // ****
   task t_ext;
      rst_low = 1;
      step(1);
      rst_low = 0;
      step(20);
      chk("glitch", 1'b1, rqo_n);
      rst_low = 1;
      step(20);
      chk("reset_out", 1'b0, rqo_n);
      chk("sys_reset", 1'b1, sr);
      rst_low = 0;
      step(10);
      chk("reset_out", 1'b1, rqo_n);
      chk("autostart", 1'b1, wa);
      ps_n = 0;
      step(4);
      chk("held", 1'b1, wa);
      $display("t_ext done");
   endtask : t_ext
   task t_src;
      wdt = 1;
      step(3);
      chk("wdt", 1'b0, rqo_n);
      wdt = 0;
      step(8);
      chk("autostart", 1'b0, wa);
      osc = 1;
      step(3);
      chk("osc", 1'b0, rqo_n);
      chk("owd_on", 1'b1, ow);
      // strap moved only while the device is held in reset
      osc = 0;
      wdt = 1;
      wdog_en = 0;
      step(8);
      wdt = 0;
      step(4);
      chk("owd_off", 1'b0, ow);
      osc = 1;
      step(4);
      chk("osc_off", 1'b1, rqo_n);
      osc = 0;
      wdt = 1;
      wdog_en = 1;
      step(4);
      wdt = 0;
      step(4);
      $display("t_src done");
   endtask : t_src
   task t_ps;
      psr = 1;
      step(5);
      chk("grant", 1'b1, pg);
      ps_n = 1;
      step(5);
      chk("blocked", 1'b0, pg);
      psr = 0;
      ps_n = 0;
      $display("t_ps done");
   endtask : t_ps
   task t_pd;
      pd_low = 1;
      step(14);
      pd_low = 0;
      step(5);
      chk("pd_rst", 1'b0, rqo_n);
      step(12);
      pd_low = 1;
      step(30);
      chk("powerdown", 1'b1, pdn);
      chk("float", 1'b1, pf);
      pd_low = 0;
      step(20);
      chk("pd_exit", 1'b0, pdn);
      $display("t_pd done");
   endtask : t_pd
   initial
   begin
      step(10);
      rst = 0;
      step(8);
      t_ext();
      t_src();
      t_ps();
      t_pd();
      give_verdict();
   end
   // run is about 200 cycles
   initial
   begin
      #40000;
      errors++;
      give_verdict();
   end
endmodule : rsc_top_tb
